// ==== core/adcoc_defines.svh ====
// register offsets, field positions, reset values and write masks of the offset/mode bank
// How it works
// - with correction on, each channel output settles at midcode plus its programmed pedestal.
// - on the wide variant the six-bit pedestal is two's complement, -32 to +31, zero is midcode.
// - on the narrow variant only the upper four pedestal bits count, -8 to +7 around midcode.
// - channel A and channel B each keep their own pedestal register.
// - freeze clear keeps the estimate updating; freeze set holds and applies the last estimate.
// - the loop time constant is a four-bit field counted in sample clock cycles.
// - a one-bit field enables slow-rate mode for channel B, used only after the master enable.
// - a one-bit field enables slow-rate mode for channel A, used only after the master enable.
// - the master slow-rate bit keeps slow-rate off at 0 and hands control to channel bits at 1.
// - the two-bit swing field disables swing control at 00 and enables it at 11.
// - every register of the bank resets to zero.
`ifndef ADCOC_DEFINES_SVH
`define ADCOC_DEFINES_SVH
`define ADCOC_OFS_PED_A     8'hbf
`define ADCOC_OFS_PED_B     8'hc1
`define ADCOC_OFS_LOOP      8'hcf
`define ADCOC_OFS_SLOW_B    8'hdb
`define ADCOC_OFS_SLOW_MST  8'hef
`define ADCOC_OFS_SWING     8'hf1
`define ADCOC_OFS_SLOW_A    8'hf2
`define ADCOC_OFS_LOOP_EN   8'hf8
`define ADCOC_OFS_STATUS    8'hfc
`define ADCOC_PED_MSB       7
`define ADCOC_PED_LSB       2
`define ADCOC_HOLD_BIT      7
`define ADCOC_TC_MSB        5
`define ADCOC_TC_LSB        2
`define ADCOC_SLOW_B_BIT    0
`define ADCOC_SLOW_A_BIT    3
`define ADCOC_SLOW_MST_BIT  4
`define ADCOC_SWING_MSB     1
`define ADCOC_SWING_ON      2'h3
`define ADCOC_RST_VAL       8'h00
`define ADCOC_MASK_PED      8'hfc
`define ADCOC_MASK_LOOP     8'hbc
`define ADCOC_MASK_SLOW_B   8'h01
`define ADCOC_MASK_SLOW_MST 8'h10
`define ADCOC_MASK_SWING    8'h03
`define ADCOC_MASK_SLOW_A   8'h08
`endif

// ==== core/adcoc_pkg.sv ====
// types shared by the offset/mode bank
`default_nettype none
package adcoc_pkg;
    typedef enum logic [1:0] {
        ADCOC_TRACK  = 2'h0,
        ADCOC_FROZEN = 2'h1
    } adcoc_loop_t;
endpackage : adcoc_pkg
`default_nettype wire

// ==== core/adcoc_loop.sv ====
// one channel of the dc offset correction loop
`include "adcoc_defines.svh"
`default_nettype none
module adcoc_loop #(
    parameter int DW = 14
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          enable,
    input  wire logic          hold,
    input  wire logic          wide,
    input  wire logic [5:0]    pedestal,
    input  wire logic [3:0]    settle_cycles,
    input  wire logic          sample_en,
    input  wire logic [DW-1:0] raw,
    output logic      [DW-1:0] corr_q,
    output logic      [DW-1:0] est_q,
    output logic               frozen_q
);
    adcoc_pkg::adcoc_loop_t state_q;
    logic [3:0]    tick_q;
    logic [DW-1:0] target;
    logic [DW-1:0] ped_ext;
    logic [DW-1:0] mid;
    logic [DW-1:0] err;
    logic          tick_done;

    assign mid = {1'b1, {(DW-1){1'b0}}};
    // narrow variant keeps only the upper four pedestal bits
    assign ped_ext = wide ? {{(DW-6){pedestal[5]}}, pedestal}
                          : {{(DW-4){pedestal[5]}}, pedestal[5:2]};
    assign target = mid + ped_ext;
    assign err = raw - est_q - target;
    assign tick_done = (tick_q >= settle_cycles);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= adcoc_pkg::ADCOC_TRACK;
        end else begin
            case (state_q)
                adcoc_pkg::ADCOC_TRACK:  if (enable && hold) state_q <= adcoc_pkg::ADCOC_FROZEN;
                adcoc_pkg::ADCOC_FROZEN: if (!hold) state_q <= adcoc_pkg::ADCOC_TRACK;
                default:                 state_q <= adcoc_pkg::ADCOC_TRACK;
            endcase
        end
    end

    // loop time constant counted in sample cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 4'h0;
        end else if (sample_en) begin
            tick_q <= tick_done ? 4'h0 : tick_q + 4'h1;
        end
    end

    // estimate steps one lsb per time constant, which trades settling speed for noise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            est_q <= '0;
        end else if (!enable) begin
            est_q <= '0;
        end else if (sample_en && tick_done && state_q == adcoc_pkg::ADCOC_TRACK) begin
            if (err[DW-1]) begin
                est_q <= est_q - {{(DW-1){1'b0}}, 1'b1};
            end else if (err != '0) begin
                est_q <= est_q + {{(DW-1){1'b0}}, 1'b1};
            end
        end
    end

    // frozen estimate still applied on every sample_en cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            corr_q <= '0;
        end else if (sample_en) begin
            corr_q <= enable ? raw - est_q : raw;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frozen_q <= 1'b0;
        end else begin
            frozen_q <= (state_q == adcoc_pkg::ADCOC_FROZEN);
        end
    end

    a_freeze_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == adcoc_pkg::ADCOC_FROZEN && enable && $past(enable)
         && $past(state_q) == adcoc_pkg::ADCOC_FROZEN) |-> $stable(est_q))
        else $error("estimate moved while frozen");
    a_tick_bound: assert property (@(posedge pclk) disable iff (!presetn)
        sample_en && tick_done |=> tick_q == 4'h0)
        else $error("time constant counter did not wrap");
endmodule : adcoc_loop
`default_nettype wire

// ==== core/adcoc_regs.sv ====
// apb register bank for dc offset loop, slow-rate modes and swing control
//
// Implementation choice: the APB register port.
`include "adcoc_defines.svh"
`default_nettype none
module adcoc_regs #(
    parameter int DW   = 14,
    parameter bit WIDE = 1'b1,
    parameter bit HAS_SLOW_MST = 1'b1
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic               pready,
    output logic      [31:0]   prdata,
    output logic               pslverr,
    input  wire logic          sample_en,
    input  wire logic [DW-1:0] raw_a,
    input  wire logic [DW-1:0] raw_b,
    output logic      [DW-1:0] corr_a_q,
    output logic      [DW-1:0] corr_b_q,
    output logic               slow_rate_a_q,
    output logic               slow_rate_b_q,
    output logic               swing_ctrl_q
);
    logic [7:0]    ped_a_q;
    logic [7:0]    ped_b_q;
    logic [7:0]    loop_q;
    logic [7:0]    slow_b_q;
    logic [7:0]    slow_mst_q;
    logic [7:0]    swing_q;
    logic [7:0]    slow_a_q;
    logic          loop_en_q;
    logic [DW-1:0] est_a;
    logic [DW-1:0] est_b;
    logic          frz_a;
    logic          frz_b;
    logic          wr_acc;
    logic          rd_acc;
    logic [7:0]    widx;
    logic          hit;
    logic [7:0]    rd_val;

    // byte offsets are word indices; word address is offset times four
    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx == `ADCOC_OFS_PED_A) || (idx == `ADCOC_OFS_PED_B)
              || (idx == `ADCOC_OFS_LOOP) || (idx == `ADCOC_OFS_SLOW_B)
              || (idx == `ADCOC_OFS_SLOW_MST) || (idx == `ADCOC_OFS_SWING)
              || (idx == `ADCOC_OFS_SLOW_A) || (idx == `ADCOC_OFS_LOOP_EN)
              || (idx == `ADCOC_OFS_STATUS);
    endfunction : mapped

    function automatic logic wr_hit(input logic [7:0] idx, input logic [7:0] ofs);
        wr_hit = (idx == ofs);
    endfunction : wr_hit

    assign widx   = paddr[9:2];
    assign hit    = mapped(widx) && (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    assign wr_acc = psel && penable && pwrite && hit && pstrb[0];
    assign rd_acc = psel && penable && !pwrite;

    // unassigned bits are masked so they read back zero whatever is written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ped_a_q    <= `ADCOC_RST_VAL;
            ped_b_q    <= `ADCOC_RST_VAL;
            loop_q     <= `ADCOC_RST_VAL;
            slow_b_q   <= `ADCOC_RST_VAL;
            slow_mst_q <= `ADCOC_RST_VAL;
            swing_q    <= `ADCOC_RST_VAL;
            slow_a_q   <= `ADCOC_RST_VAL;
            loop_en_q  <= 1'b0;
        end else if (wr_acc) begin
            if (wr_hit(widx, `ADCOC_OFS_PED_A)) begin
                ped_a_q <= pwdata[7:0] & `ADCOC_MASK_PED;
            end
            if (wr_hit(widx, `ADCOC_OFS_PED_B)) begin
                ped_b_q <= pwdata[7:0] & `ADCOC_MASK_PED;
            end
            if (wr_hit(widx, `ADCOC_OFS_LOOP)) begin
                loop_q <= pwdata[7:0] & `ADCOC_MASK_LOOP;
            end
            if (wr_hit(widx, `ADCOC_OFS_SLOW_B)) begin
                slow_b_q <= pwdata[7:0] & `ADCOC_MASK_SLOW_B;
            end
            if (wr_hit(widx, `ADCOC_OFS_SLOW_MST) && HAS_SLOW_MST) begin
                slow_mst_q <= pwdata[7:0] & `ADCOC_MASK_SLOW_MST;
            end
            if (wr_hit(widx, `ADCOC_OFS_SWING)) begin
                swing_q <= pwdata[7:0] & `ADCOC_MASK_SWING;
            end
            if (wr_hit(widx, `ADCOC_OFS_SLOW_A)) begin
                slow_a_q <= pwdata[7:0] & `ADCOC_MASK_SLOW_A;
            end
            if (wr_hit(widx, `ADCOC_OFS_LOOP_EN)) begin
                loop_en_q <= pwdata[0];
            end
        end
    end

    always_comb begin
        rd_val = 8'h00;
        case (widx)
            `ADCOC_OFS_PED_A:    rd_val = ped_a_q;
            `ADCOC_OFS_PED_B:    rd_val = ped_b_q;
            `ADCOC_OFS_LOOP:     rd_val = loop_q;
            `ADCOC_OFS_SLOW_B:   rd_val = slow_b_q;
            `ADCOC_OFS_SLOW_MST: rd_val = slow_mst_q;
            `ADCOC_OFS_SWING:    rd_val = swing_q;
            `ADCOC_OFS_SLOW_A:   rd_val = slow_a_q;
            `ADCOC_OFS_LOOP_EN:  rd_val = {7'h00, loop_en_q};
            `ADCOC_OFS_STATUS:   rd_val = {2'h0, swing_ctrl_q, slow_rate_b_q, slow_rate_a_q,
                                           frz_b, frz_a, loop_en_q};
            default:             rd_val = 8'h00;
        endcase
    end

    // zero wait states: pready high in every access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata  <= (psel && !penable && !pwrite && hit) ? {24'h00_0000, rd_val}
                                                           : 32'h0000_0000;
        end
    end

    // per-channel bits count only when the master bit hands them control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_rate_a_q <= 1'b0;
            slow_rate_b_q <= 1'b0;
        end else begin
            slow_rate_a_q <= slow_mst_q[`ADCOC_SLOW_MST_BIT] && slow_a_q[`ADCOC_SLOW_A_BIT];
            slow_rate_b_q <= slow_mst_q[`ADCOC_SLOW_MST_BIT] && slow_b_q[`ADCOC_SLOW_B_BIT];
        end
    end

    // reserved codes 01 and 10 leave swing control off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swing_ctrl_q <= 1'b0;
        end else begin
            swing_ctrl_q <= (swing_q[`ADCOC_SWING_MSB:0] == `ADCOC_SWING_ON);
        end
    end

    adcoc_loop #(.DW(DW)) u_loop_a (
        .pclk          (pclk),
        .presetn       (presetn),
        .enable        (loop_en_q),
        .hold          (loop_q[`ADCOC_HOLD_BIT]),
        .wide          (WIDE),
        .pedestal      (ped_a_q[`ADCOC_PED_MSB:`ADCOC_PED_LSB]),
        .settle_cycles (loop_q[`ADCOC_TC_MSB:`ADCOC_TC_LSB]),
        .sample_en     (sample_en),
        .raw           (raw_a),
        .corr_q        (corr_a_q),
        .est_q         (est_a),
        .frozen_q      (frz_a)
    );

    adcoc_loop #(.DW(DW)) u_loop_b (
        .pclk          (pclk),
        .presetn       (presetn),
        .enable        (loop_en_q),
        .hold          (loop_q[`ADCOC_HOLD_BIT]),
        .wide          (WIDE),
        .pedestal      (ped_b_q[`ADCOC_PED_MSB:`ADCOC_PED_LSB]),
        .settle_cycles (loop_q[`ADCOC_TC_MSB:`ADCOC_TC_LSB]),
        .sample_en     (sample_en),
        .raw           (raw_b),
        .corr_q        (corr_b_q),
        .est_q         (est_b),
        .frozen_q      (frz_b)
    );

    sequence s_wr_ped_a;
        psel && penable && pwrite && pready && pstrb[0] && paddr == 12'h2fc;
    endsequence
    a_ped_a_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_ped_a |=> ped_a_q == ($past(pwdata[7:0]) & `ADCOC_MASK_PED))
        else $error("channel A pedestal not stored");
    a_ped_b_apart: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_ped_a |=> $stable(ped_b_q))
        else $error("channel B pedestal changed by channel A write");
    a_slow_a_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(slow_mst_q[`ADCOC_SLOW_MST_BIT]) |-> !slow_rate_a_q)
        else $error("slow rate A on without master");
    a_slow_b_gate: assert property (@(posedge pclk) disable iff (!presetn)
        $past(slow_mst_q[`ADCOC_SLOW_MST_BIT] && slow_b_q[`ADCOC_SLOW_B_BIT]) |-> slow_rate_b_q)
        else $error("slow rate B not following its bit");
    a_master_off: assert property (@(posedge pclk) disable iff (!presetn)
        (slow_mst_q == 8'h00)[*2] |-> !slow_rate_a_q && !slow_rate_b_q)
        else $error("slow rate active with master clear");
    a_swing_code: assert property (@(posedge pclk) disable iff (!presetn)
        swing_ctrl_q |-> $past(swing_q[1:0]) == 2'h3)
        else $error("swing control on without code 11");
    a_reset_zero: assert property (@(posedge pclk)
        $rose(presetn) |-> loop_q == 8'h00 && ped_a_q == 8'h00 && swing_q == 8'h00)
        else $error("bank not zero after reset");
    a_no_wait: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready)
        else $error("access phase without ready");
    a_target_mid: assert property (@(posedge pclk) disable iff (!presetn)
        (u_loop_a.target < {1'b1, {(DW-1){1'b0}}}) == ped_a_q[7])
        else $error("target on wrong side of midcode");
endmodule : adcoc_regs
`default_nettype wire

// ==== bench/adcoc_host_model.sv ====
// apb host model that programs the offset/mode bank
`default_nettype none
module adcoc_host_model (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hung;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        hung = 1'b0;
    end
    // callers pass zero in unassigned bits and swing codes 00 or 11 only
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        hung = (n >= 50);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines flip so stale values cannot pass
        paddr <= ~a;
        pwdata <= ~{24'h0, d};
        pstrb <= 4'h0;
        @(posedge pclk);
    endtask : xfer
endmodule : adcoc_host_model
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench of the offset/mode register bank
`include "adcoc_defines.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [13:0] raw_a, raw_b, corr_a, corr_b, corr2_a, corr2_b;
    logic        slow_a, slow_b, swing;
    int          num_errors, total_checks;
    adcoc_host_model host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb));
    adcoc_regs DUT (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .sample_en(sample_en), .raw_a(raw_a), .raw_b(raw_b), .corr_a_q(corr_a),
        .corr_b_q(corr_b), .slow_rate_a_q(slow_a), .slow_rate_b_q(slow_b),
        .swing_ctrl_q(swing));
    // narrow variant shares the bus; only the wide one answers to the host
    adcoc_regs #(.WIDE(1'b0)) DUT2 (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(), .prdata(), .pslverr(),
        .sample_en(sample_en), .raw_a(raw_a), .raw_b(raw_b), .corr_a_q(corr2_a),
        .corr_b_q(corr2_b), .slow_rate_a_q(), .slow_rate_b_q(), .swing_ctrl_q());
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic final_report();
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk
    function automatic logic [11:0] a4(input logic [7:0] o);
        return {2'b00, o, 2'b00};
    endfunction : a4
    function automatic logic [13:0] pick(input int i);
        case (i)
            0: return corr_a;
            1: return corr_b;
            2: return corr2_a;
            default: return corr2_b;
        endcase
    endfunction : pick
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        host.xfer(1'b1, a4(o), d, r, e);
        if (host.hung) begin
            num_errors++;
            final_report();
        end
        // mode outputs sit two flops behind the write
        @(posedge pclk);
    endtask : wr
    task automatic rd(input logic [7:0] o, input logic [7:0] x, input logic xe, input string nm);
        logic [7:0] r;
        logic e;
        host.xfer(1'b0, a4(o), 8'h00, r, e);
        if (host.hung) begin
            num_errors++;
            final_report();
        end
        chk(nm, {24'h0, x}, {24'h0, r});
        chk("pslverr", {31'h0, xe}, {31'h0, e});
    endtask : rd
    task automatic wait_eq(input int i, input logic [13:0] e, input int lim, input string nm);
        int n;
        n = 0;
        while (pick(i) !== e && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk(nm, {18'h0, e}, {18'h0, pick(i)});
        if (pick(i) !== e) final_report();
    endtask : wait_eq
    task automatic t_reset();
        logic [7:0] ofs [7];
        ofs = '{`ADCOC_OFS_PED_A, `ADCOC_OFS_PED_B, `ADCOC_OFS_LOOP, `ADCOC_OFS_SLOW_B,
                `ADCOC_OFS_SLOW_MST, `ADCOC_OFS_SWING, `ADCOC_OFS_SLOW_A};
        foreach (ofs[i]) rd(ofs[i], 8'h00, 1'b0, "reset_value");
        chk("reset_outs", 32'h0, {29'h0, slow_a, slow_b, swing});
        rd(8'h00, 8'h00, 1'b1, "unmapped");
    endtask : t_reset
    task automatic t_slow_swing();
        wr(`ADCOC_OFS_SLOW_A, 8'h08);
        wr(`ADCOC_OFS_SLOW_B, 8'h01);
        chk("slow_no_master", 32'h0, {30'h0, slow_a, slow_b});
        wr(`ADCOC_OFS_SLOW_MST, 8'h10);
        chk("slow_both", 32'h3, {30'h0, slow_a, slow_b});
        wr(`ADCOC_OFS_SLOW_A, 8'h00);
        chk("slow_b_only", 32'h1, {30'h0, slow_a, slow_b});
        wr(`ADCOC_OFS_SWING, 8'h03);
        chk("swing_on", 32'h1, {31'h0, swing});
        wr(`ADCOC_OFS_SWING, 8'h00);
        chk("swing_off", 32'h0, {31'h0, swing});
    endtask : t_slow_swing
    task automatic t_pedestal();
        wr(`ADCOC_OFS_PED_A, 8'h7c);
        wr(`ADCOC_OFS_PED_B, 8'h80);
        rd(`ADCOC_OFS_PED_A, 8'h7c, 1'b0, "ped_a_back");
        wr(`ADCOC_OFS_LOOP_EN, 8'h01);
        wait_eq(0, 14'h201f, 300, "corr_a_plus31");
        wait_eq(1, 14'h1fe0, 300, "corr_b_minus32");
        wait_eq(2, 14'h2007, 300, "narrow_a_plus7");
        wait_eq(3, 14'h1ff8, 300, "narrow_b_minus8");
    endtask : t_pedestal
    task automatic t_freeze();
        // enable stays set while freeze is used
        wr(`ADCOC_OFS_LOOP, 8'h80);
        rd(`ADCOC_OFS_STATUS, 8'h17, 1'b0, "status_frozen");
        raw_a <= 14'h2004;
        repeat (40) @(posedge pclk);
        chk("frozen_a", 32'h2023, {18'h0, corr_a});
        chk("frozen_narrow", 32'h200b, {18'h0, corr2_a});
        wr(`ADCOC_OFS_LOOP, 8'h00);
        wait_eq(0, 14'h201f, 300, "unfrozen_a");
    endtask : t_freeze
    task automatic t_settle();
        // two steps of sixteen samples cannot finish in twelve cycles
        wr(`ADCOC_OFS_LOOP, 8'h3c);
        raw_a <= 14'h2006;
        repeat (12) @(posedge pclk);
        chk("slow_settle", 32'h0, {31'h0, corr_a === 14'h201f});
        wait_eq(0, 14'h201f, 100, "settled_a");
        wr(`ADCOC_OFS_LOOP_EN, 8'h00);
        wait_eq(0, 14'h2006, 5, "loop_off_raw");
        sample_en <= 1'b0;
        raw_a <= 14'h2010;
        raw_b <= 14'h1ff0;
        repeat (4) @(posedge pclk);
        chk("hold_no_sample", 32'h2006, {18'h0, corr_a});
        sample_en <= 1'b1;
        wait_eq(0, 14'h2010, 5, "sample_resume");
        wait_eq(1, 14'h1ff0, 5, "pass_b");
    endtask : t_settle
    initial begin
        presetn = 1'b0;
        sample_en = 1'b1;
        raw_a = 14'h2000;
        raw_b = 14'h2000;
        num_errors = 0;
        total_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_slow_swing();
        t_pedestal();
        t_freeze();
        t_settle();
        final_report();
    end
endmodule : tb
`default_nettype wire
